// File: hw/tsr_pkg.sv
// Package of constants and carrier types for the telemetry and status bank.
package tsr_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_COEF_FIRST = 8'he3;
	localparam logic [7:0] CMD_COEF_LAST = 8'he6;
	localparam logic [7:0] CMD_FAULT_WORD = 8'h79;
	localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
	localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
	localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
	localparam logic [7:0] CMD_THERM_FLAGS = 8'h7d;
	localparam logic [7:0] CMD_COMM_FLAGS = 8'h7e;
	localparam logic [7:0] CMD_VIN_READ = 8'h88;
	localparam logic [7:0] CMD_VOUT_READ = 8'h8b;
	localparam logic [7:0] CMD_IOUT_READ = 8'h8c;
	localparam logic [7:0] CMD_TEMP_READ = 8'h8d;
	localparam logic [7:0] CMD_VOUT_TRIM_OFS = 8'hd0;
	localparam logic [7:0] CMD_VIN_TRIM_OFS = 8'hd1;
	localparam logic [7:0] CMD_VIN_TRIM_GAIN = 8'hd2;
	localparam logic [7:0] CMD_IOUT_TRIM_OFS = 8'hd3;
	localparam logic [7:0] CMD_IOUT_TRIM_GAIN = 8'hd4;

	// ----------------------------------------------------------------
	// Number formats
	// ----------------------------------------------------------------
	localparam logic [4:0] EXP_MINUS3 = 5'h1d;
	localparam logic [4:0] EXP_MINUS2 = 5'h1e;
	localparam int GAIN_SHIFT = 13;
	localparam logic [10:0] MANT_MAX = 11'h3ff;
	localparam int BLANK_MILLIAMP = 1650;
	localparam int IOUT_LSB_MILLIAMP = 125;
	localparam int TC_SHIFT = 12;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_PGOOD_N = 11;
	localparam int SW_OFF = 6;
	localparam int SW_VOUT_OV = 5;
	localparam int SW_IOUT_OC = 4;
	localparam int SW_VIN_UV = 3;
	localparam int SW_TEMP = 2;
	localparam int SW_CML = 1;
	localparam int VF_OV = 7;
	localparam int IF_OC = 7;
	localparam int IF_OC_WARN = 5;
	localparam int INF_OV = 7;
	localparam int INF_UV = 4;
	localparam int INF_LOW_OFF = 3;
	localparam int TF_OT = 7;
	localparam int TF_OT_WARN = 6;
	localparam int CF_CMD = 7;
	localparam int CF_DATA = 6;
	localparam int CF_PEC = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] PROP_RESET = 16'h08fc;
	localparam logic [15:0] INTEG_RESET = 16'h002d;
	localparam logic [15:0] DERIV_RESET = 16'hfb50;
	localparam logic [15:0] FILT_RESET = 16'h00c8;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
		logic pecOk;
	} tsr_req_t;

	typedef struct packed {
		logic [15:0] voutOfs;
		logic [10:0] vinOfs;
		logic [15:0] vinGain;
		logic [10:0] ioutOfs;
		logic [15:0] ioutGain;
	} tsr_cal_t;

	typedef struct packed {
		logic [15:0] voutRaw;
		logic [10:0] vinRaw;
		logic [10:0] ioutRaw;
		logic ioutSink;
		logic [10:0] tempRaw;
	} tsr_meas_t;

	typedef struct packed {
		logic voutOv;
		logic ioutOc;
		logic ioutOcWarn;
		logic vinOv;
		logic vinUv;
		logic lowVinOff;
		logic otFault;
		logic otWarn;
		logic powerNotGood;
		logic outputOff;
	} tsr_evt_t;

	typedef struct packed {
		logic [15:0] proportional;
		logic [15:0] integral;
		logic [15:0] derivative;
		logic [15:0] filter;
	} tsr_loop_t;

endpackage

// File: hw/tsr_telemetry_status_regs.sv
// Telemetry readings, trim values, loop coefficients and status flags.
`timescale 1ns/1ns

// Summary of operation
// - Four loop coefficients read/write at codes E3-E6
// - Output voltage: unsigned 16-bit mantissa, exponent -12
// - Output voltage adds signed factory offset
// - Input voltage linear, exponent -3, nonnegative
// - Input offset trim: exponent -3, signed mantissa
// - Input reading scaled by gain over 8192
// - Output current linear, exponent -3, nonnegative
// - Current below blanking threshold reads zero
// - Current offset trim: exponent -3, signed mantissa
// - Current reading scaled by gain over 8192
// - Sinking current reads as zero
// - Current reading is temperature compensated
// - Temperature linear, exponent -2, signed mantissa
// - Summary word with documented bit positions
// - Output voltage byte: overvoltage in bit 7
// - Current byte: fault bit 7, warning bit 5
// - Input byte: bits 7, 4 and 3
// - Thermal byte: fault bit 7, warning 6
// - Comm byte: command 7, data 6, checksum 5
// - Unsupported status bits read zero, all reset zero
// - Clear-faults command clears latched flags
module tsr_telemetry_status_regs
	import tsr_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic srst,
	// Command port from the bus engine.
	input tsr_req_t req,
	output logic rspValid_r,
	output logic rspNack_r,
	output logic [15:0] rspData_r,
	// Measurements, factory trims and fault conditions.
	input tsr_meas_t meas,
	input tsr_cal_t cal,
	input tsr_evt_t evt,
	// Coefficients to the control loop.
	output tsr_loop_t loopCoef
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Scales a raw mantissa by gain/8192, adds a signed offset, clamps.
	function automatic logic [10:0] gain_correct(input logic [10:0] raw,
			input logic [15:0] gain, input logic [10:0] ofs);
		logic [26:0] prod;
		logic signed [16:0] sum;
		prod = raw * gain;
		sum = $signed({3'b000, prod[26:GAIN_SHIFT]})
			+ $signed({{6{ofs[10]}}, ofs});
		if (sum < 0) begin
			return 11'h000;
		end else if (sum > $signed({6'h00, MANT_MAX})) begin
			return MANT_MAX;
		end else begin
			return sum[10:0];
		end
	endfunction

	// Tells whether a command code names a readable value.
	function automatic logic is_readable(input logic [7:0] code);
		case (code)
			CMD_FAULT_WORD, CMD_VOUT_FLAGS, CMD_IOUT_FLAGS,
			CMD_INPUT_FLAGS, CMD_THERM_FLAGS, CMD_COMM_FLAGS,
			CMD_VIN_READ, CMD_VOUT_READ, CMD_IOUT_READ, CMD_TEMP_READ,
			CMD_VOUT_TRIM_OFS, CMD_VIN_TRIM_OFS, CMD_VIN_TRIM_GAIN,
			CMD_IOUT_TRIM_OFS, CMD_IOUT_TRIM_GAIN: begin
				return 1'b1;
			end
			default: begin
				return (code >= CMD_COEF_FIRST) && (code <= CMD_COEF_LAST);
			end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	logic isCoef;
	logic known;
	logic pecBad;
	logic doClear;
	logic doCoefWr;
	logic badCmd;
	logic badData;
	logic [1:0] coefIdx;

	// Classifies the request; a write with a bad checksum neither clears, writes a coefficient nor flags bad data.
	assign isCoef = (req.code >= CMD_COEF_FIRST) && (req.code <= CMD_COEF_LAST);
	assign known = is_readable(req.code) || (req.code == CMD_CLEAR_FAULTS);
	assign pecBad = req.valid && req.write && !req.pecOk;
	assign doClear = req.valid && req.write && req.pecOk
		&& (req.code == CMD_CLEAR_FAULTS);
	assign doCoefWr = req.valid && req.write && req.pecOk && isCoef;
	assign badCmd = req.valid && !known;
	assign badData = req.valid && req.write && req.pecOk && known
		&& !isCoef && (req.code != CMD_CLEAR_FAULTS);
	assign coefIdx = 2'(req.code - CMD_COEF_FIRST);

	// ----------------------------------------------------------------
	// Loop coefficients
	// ----------------------------------------------------------------

	// Coefficients written by the host steer the control loop directly.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			loopCoef <= '{PROP_RESET, INTEG_RESET, DERIV_RESET, FILT_RESET};
		end else if (doCoefWr) begin
			case (coefIdx)
				2'h0: loopCoef.proportional <= req.data;
				2'h1: loopCoef.integral <= req.data;
				2'h2: loopCoef.derivative <= req.data;
				default: loopCoef.filter <= req.data;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Corrected readings
	// ----------------------------------------------------------------
	logic [15:0] voutRead_r;
	logic [10:0] vinMant_r;
	logic [10:0] ioutMant_r;
	logic [16:0] voutSum;
	logic [10:0] ioutTc;
	logic [10:0] ioutCorr;
	logic signed [22:0] tcProd;
	logic signed [12:0] tcSum;

	// Output voltage plus signed offset, clamped to the 16-bit range.
	assign voutSum = {1'b0, meas.voutRaw}
		+ {cal.voutOfs[15], cal.voutOfs};

	// Current scaled by temperature before gain and offset are applied.
	assign tcProd = $signed({1'b0, meas.ioutRaw}) * $signed(meas.tempRaw);
	assign tcSum = $signed({2'b00, meas.ioutRaw})
		+ 13'(tcProd >>> TC_SHIFT);
	assign ioutTc = tcSum < 0 ? 11'h000 :
		(tcSum > $signed({2'b00, MANT_MAX}) ? MANT_MAX : tcSum[10:0]);
	assign ioutCorr = gain_correct(ioutTc, cal.ioutGain, cal.ioutOfs);

	// Readings are refreshed every cycle from the measurements.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			voutRead_r <= WORD_RESET;
		end else if (cal.voutOfs[15] && voutSum[16]) begin
			voutRead_r <= WORD_RESET;
		end else if (!cal.voutOfs[15] && voutSum[16]) begin
			voutRead_r <= 16'hffff;
		end else begin
			voutRead_r <= voutSum[15:0];
		end
	end

	// Input voltage through gain and offset trim.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			vinMant_r <= 11'h000;
		end else begin
			vinMant_r <= gain_correct(meas.vinRaw, cal.vinGain,
				cal.vinOfs);
		end
	end

	// Output current, zero while sinking or below the blanking level.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ioutMant_r <= 11'h000;
		end else if (meas.ioutSink) begin
			ioutMant_r <= 11'h000;
		end else if (int'(ioutCorr) * IOUT_LSB_MILLIAMP < BLANK_MILLIAMP) begin
			ioutMant_r <= 11'h000;
		end else begin
			ioutMant_r <= ioutCorr;
		end
	end

	// ----------------------------------------------------------------
	// Sticky status bytes
	// ----------------------------------------------------------------
	logic [7:0] voutFlags_r;
	logic [7:0] ioutFlags_r;
	logic [7:0] inFlags_r;
	logic [7:0] thermFlags_r;
	logic [7:0] commFlags_r;
	logic [7:0] voutSet;
	logic [7:0] ioutSet;
	logic [7:0] inSet;
	logic [7:0] thermSet;
	logic [7:0] commSet;

	// Only the supported bits can ever be set; the rest stay zero.
	always_comb begin
		voutSet = 8'h00;
		ioutSet = 8'h00;
		inSet = 8'h00;
		thermSet = 8'h00;
		commSet = 8'h00;
		voutSet[VF_OV] = evt.voutOv;
		ioutSet[IF_OC] = evt.ioutOc;
		ioutSet[IF_OC_WARN] = evt.ioutOcWarn;
		inSet[INF_OV] = evt.vinOv;
		inSet[INF_UV] = evt.vinUv;
		inSet[INF_LOW_OFF] = evt.lowVinOff;
		thermSet[TF_OT] = evt.otFault;
		thermSet[TF_OT_WARN] = evt.otWarn;
		commSet[CF_CMD] = badCmd;
		commSet[CF_DATA] = badData;
		commSet[CF_PEC] = pecBad;
	end

	// Flags latch and hold until cleared; a new event beats the clear.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			voutFlags_r <= FLAGS_RESET;
			ioutFlags_r <= FLAGS_RESET;
			inFlags_r <= FLAGS_RESET;
			thermFlags_r <= FLAGS_RESET;
			commFlags_r <= FLAGS_RESET;
		end else begin
			voutFlags_r <= (voutFlags_r & ~{8{doClear}}) | voutSet;
			ioutFlags_r <= (ioutFlags_r & ~{8{doClear}}) | ioutSet;
			inFlags_r <= (inFlags_r & ~{8{doClear}}) | inSet;
			thermFlags_r <= (thermFlags_r & ~{8{doClear}}) | thermSet;
			commFlags_r <= (commFlags_r & ~{8{doClear}}) | commSet;
		end
	end

	// ----------------------------------------------------------------
	// Summary word
	// ----------------------------------------------------------------
	logic [15:0] summary;

	// Summary bits are ORs of, or single bits from, the detailed bytes plus two live levels.
	always_comb begin
		summary = WORD_RESET;
		summary[SW_VOUT] = |voutFlags_r;
		summary[SW_IOUT] = |ioutFlags_r;
		summary[SW_INPUT] = |inFlags_r;
		summary[SW_PGOOD_N] = evt.powerNotGood;
		summary[SW_OFF] = evt.outputOff;
		summary[SW_VOUT_OV] = voutFlags_r[VF_OV];
		summary[SW_IOUT_OC] = ioutFlags_r[IF_OC];
		summary[SW_VIN_UV] = inFlags_r[INF_UV];
		summary[SW_TEMP] = |thermFlags_r;
		summary[SW_CML] = |commFlags_r;
	end

	// ----------------------------------------------------------------
	// Read response
	// ----------------------------------------------------------------
	logic [15:0] rdMux;

	// Selects the value for the requested command code.
	always_comb begin
		rdMux = WORD_RESET;
		case (req.code)
			CMD_FAULT_WORD: rdMux = summary;
			CMD_VOUT_FLAGS: rdMux = {8'h00, voutFlags_r};
			CMD_IOUT_FLAGS: rdMux = {8'h00, ioutFlags_r};
			CMD_INPUT_FLAGS: rdMux = {8'h00, inFlags_r};
			CMD_THERM_FLAGS: rdMux = {8'h00, thermFlags_r};
			CMD_COMM_FLAGS: rdMux = {8'h00, commFlags_r};
			CMD_VOUT_READ: rdMux = voutRead_r;
			CMD_VIN_READ: rdMux = {EXP_MINUS3, vinMant_r};
			CMD_IOUT_READ: rdMux = {EXP_MINUS3, ioutMant_r};
			CMD_TEMP_READ: rdMux = {EXP_MINUS2, meas.tempRaw};
			CMD_VOUT_TRIM_OFS: rdMux = cal.voutOfs;
			CMD_VIN_TRIM_OFS: rdMux = {EXP_MINUS3, cal.vinOfs};
			CMD_VIN_TRIM_GAIN: rdMux = cal.vinGain;
			CMD_IOUT_TRIM_OFS: rdMux = {EXP_MINUS3, cal.ioutOfs};
			CMD_IOUT_TRIM_GAIN: rdMux = cal.ioutGain;
			CMD_COEF_FIRST: rdMux = loopCoef.proportional;
			8'he4: rdMux = loopCoef.integral;
			8'he5: rdMux = loopCoef.derivative;
			CMD_COEF_LAST: rdMux = loopCoef.filter;
			default: rdMux = WORD_RESET;
		endcase
	end

	// Every request is answered one cycle later; unknown codes are refused.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rspValid_r <= 1'b0;
			rspNack_r <= 1'b0;
			rspData_r <= WORD_RESET;
		end else begin
			rspValid_r <= req.valid;
			rspNack_r <= badCmd || badData || pecBad;
			rspData_r <= (req.valid && !req.write) ? rdMux : WORD_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_coef_write;
		req.valid && req.write && req.pecOk
			&& req.code == CMD_COEF_FIRST;
	endsequence

	sequence s_clear;
		req.valid && req.write && req.pecOk
			&& req.code == CMD_CLEAR_FAULTS && !evt.otFault;
	endsequence

	a_coef_write: assert property (s_coef_write ##1 1'b1 |->
		loopCoef.proportional == $past(req.data))
		else $error("proportional coefficient not written");

	a_coef_read: assert property (req.valid && !req.write
		&& req.code == CMD_COEF_LAST |=> rspData_r == loopCoef.filter
		&& rspValid_r && !rspNack_r)
		else $error("filter coefficient read mismatch");

	a_vout_offset: assert property (!meas.voutRaw[15]
		&& !cal.voutOfs[15] |=> voutRead_r == 16'($past(meas.voutRaw)
		+ $past(cal.voutOfs)))
		else $error("output voltage offset not applied");

	a_iout_sink: assert property (meas.ioutSink |=>
		ioutMant_r == 11'h000)
		else $error("sinking current not reported as zero");

	a_iout_blank: assert property (ioutMant_r != 11'h000 |->
		int'(ioutMant_r) * IOUT_LSB_MILLIAMP >= BLANK_MILLIAMP)
		else $error("current below blanking threshold reported");

	a_temp_exp: assert property (req.valid && !req.write
		&& req.code == CMD_TEMP_READ
		|=> rspData_r[15:11] == EXP_MINUS2)
		else $error("temperature exponent wrong");

	a_flag_sticky: assert property ($rose(thermFlags_r[TF_OT])
		##0 !doClear [*3] |=> thermFlags_r[TF_OT])
		else $error("thermal fault flag dropped without clear");

	a_clear_faults: assert property (s_clear |=>
		thermFlags_r[TF_OT] == 1'b0)
		else $error("clear faults left thermal fault set");

	a_set_wins: assert property (doClear && evt.voutOv |=>
		voutFlags_r[VF_OV] && summary[SW_VOUT])
		else $error("event lost in clear cycle");

	a_unsupported: assert property (voutFlags_r[6:0] == 7'h00
		&& ioutFlags_r[6] == 1'b0 && thermFlags_r[5:0] == 6'h00
		&& commFlags_r[4:0] == 5'h00)
		else $error("unsupported status bit set");

	a_bad_command: assert property (req.valid && !known |=>
		commFlags_r[CF_CMD] && rspNack_r ##1 summary[SW_CML])
		else $error("unsupported command not flagged");

	a_summary_pg: assert property (summary[SW_OFF] == evt.outputOff
		&& summary[SW_PGOOD_N] == evt.powerNotGood)
		else $error("summary live bits wrong");

endmodule // tsr_telemetry_status_regs

// File: tb/tsr_host_model.sv
// Bus-engine host model that issues command requests to the status bank.
`timescale 1ns/1ns
module tsr_host_model
	import tsr_pkg::*;
(
	// Clock.
	input wire logic sys_clk,
	// Command port toward the bank.
	output tsr_req_t req,
	input wire logic rspValid_r,
	input wire logic rspNack_r,
	input wire logic [15:0] rspData_r
);

	// ----------------------------------------------------------------
	// Request driver
	// ----------------------------------------------------------------
	// The port starts idle so nothing is taken during reset.
	initial begin
		req = '0;
	end

	// One request, held for one edge, answer taken 1 ns after that same edge.
	// Released fields are inverted so a stale value is never reused.
	task automatic xfer(input logic w, input logic [7:0] code,
		input logic [15:0] data, input logic pec, output logic ok,
		output logic nack, output logic [15:0] rdata);
		@(posedge sys_clk);
		req <= '{valid: 1'b1, write: w, code: code, data: data, pecOk: pec};
		@(posedge sys_clk);
		req <= '{valid: 1'b0, write: ~w, code: ~code, data: ~data,
			pecOk: ~pec};
		#1;
		ok = rspValid_r;
		nack = rspNack_r;
		rdata = rspData_r;
	endtask

endmodule // tsr_host_model

// File: tb/tb_top.sv
// Self-checking testbench for the telemetry and status bank.
`timescale 1ns/1ns
module tb_top
	import tsr_pkg::*;
;

	// ----------------------------------------------------------------
	// Signals and tables
	// ----------------------------------------------------------------
	logic sys_clk;
	logic srst;
	tsr_req_t req;
	logic rspValid_r;
	logic rspNack_r;
	logic [15:0] rspData_r;
	tsr_meas_t meas;
	tsr_cal_t cal;
	tsr_evt_t evt;
	tsr_loop_t loopCoef;
	int error_cnt;
	int comparisons;
	logic [15:0] coefDef [4] = '{16'h08fc, 16'h002d, 16'hfb50, 16'h00c8};
	logic [9:0] evtTab [8] = '{10'h200, 10'h100, 10'h080, 10'h040,
		10'h020, 10'h010, 10'h008, 10'h004};
	logic [7:0] codeTab [8] = '{CMD_VOUT_FLAGS, CMD_IOUT_FLAGS,
		CMD_IOUT_FLAGS, CMD_INPUT_FLAGS, CMD_INPUT_FLAGS, CMD_INPUT_FLAGS,
		CMD_THERM_FLAGS, CMD_THERM_FLAGS};
	logic [7:0] byteTab [8] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08,
		8'h80, 8'h40};
	logic [15:0] wordTab [8] = '{16'h8020, 16'h4010, 16'h4000, 16'h2000,
		16'h2008, 16'h2000, 16'h0004, 16'h0004};

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	tsr_telemetry_status_regs tsr_telemetry_status_regs_i (
		.sys_clk(sys_clk), .srst(srst), .req(req), .rspValid_r(rspValid_r),
		.rspNack_r(rspNack_r), .rspData_r(rspData_r), .meas(meas),
		.cal(cal), .evt(evt), .loopCoef(loopCoef));

	tsr_host_model tsr_host_model_i (
		.sys_clk(sys_clk), .req(req), .rspValid_r(rspValid_r),
		.rspNack_r(rspNack_r), .rspData_r(rspData_r));

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	// The clock toggles every 50 ns, giving a period of 100 ns.
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// A hang is cut short well after the few hundred cycles needed.
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compares one 16-bit result and counts it.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got,
				exp);
		end
	endtask

	// Runs one transfer and checks answer, refusal and data.
	task automatic xact(input logic w, input logic [7:0] code,
		input logic [15:0] data, input logic pec, input logic expNack,
		input logic [15:0] expData);
		logic ok;
		logic nack;
		logic [15:0] rdat;
		tsr_host_model_i.xfer(w, code, data, pec, ok, nack, rdat);
		chk({15'h0, ok}, 16'h0001, "answer strobe");
		chk({15'h0, nack}, {15'h0, expNack}, "refusal flag");
		chk(rdat, expData, "response data");
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		xact(1'b0, code, 16'h0, 1'b1, 1'b0, exp);
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] data,
		input logic pec, input logic expNack);
		xact(1'b1, code, data, pec, expNack, 16'h0);
	endtask

	// Applies one current measurement and reads the current back.
	task automatic iout_case(input logic [10:0] raw, input logic [10:0] temp,
		input logic sink, input logic [10:0] mant);
		@(posedge sys_clk);
		meas.ioutRaw <= raw;
		meas.tempRaw <= temp;
		meas.ioutSink <= sink;
		rd(CMD_IOUT_READ, {5'h1d, mant});
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	// Resets the bank, then walks coefficients, readings and flags.
	initial begin
		srst = 1'b1;
		meas = '0;
		cal = '{voutOfs: 16'h0, vinOfs: 11'h0, vinGain: 16'h2000,
			ioutOfs: 11'h0, ioutGain: 16'h2000};
		evt = '0;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd(CMD_COEF_FIRST + 8'(i), coefDef[i]);
		for (int i = 0; i < 6; i++)
			rd(CMD_FAULT_WORD + 8'(i), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(CMD_COEF_FIRST + 8'(i), 16'ha5a0 + 16'(i), 1'b1, 1'b0);
			chk(loopCoef[63 - 16 * i -: 16], 16'ha5a0 + 16'(i), "coef out");
			rd(CMD_COEF_FIRST + 8'(i), 16'ha5a0 + 16'(i));
		end
		// Readings with their trims.
		@(posedge sys_clk);
		meas.voutRaw <= 16'hc000;
		cal.voutOfs <= 16'hfff0;
		meas.vinRaw <= 11'h180;
		cal.vinGain <= 16'h3000;
		cal.vinOfs <= 11'h7fe;
		cal.ioutGain <= 16'h4000;
		cal.ioutOfs <= 11'h003;
		rd(CMD_VOUT_READ, 16'hbff0);
		rd(CMD_VOUT_TRIM_OFS, 16'hfff0);
		// A negative sum clamps to zero; small positive sums add exactly.
		@(posedge sys_clk);
		meas.voutRaw <= 16'h0008;
		rd(CMD_VOUT_READ, 16'h0000);
		@(posedge sys_clk);
		meas.voutRaw <= 16'h1000;
		cal.voutOfs <= 16'h0010;
		rd(CMD_VOUT_READ, 16'h1010);
		rd(CMD_VIN_READ, {5'h1d, 11'h23e});
		rd(CMD_VIN_TRIM_OFS, {5'h1d, 11'h7fe});
		rd(CMD_VIN_TRIM_GAIN, 16'h3000);
		rd(CMD_IOUT_TRIM_OFS, {5'h1d, 11'h003});
		rd(CMD_IOUT_TRIM_GAIN, 16'h4000);
		iout_case(11'd80, 11'd0, 1'b0, 11'd163);
		iout_case(11'd80, 11'd512, 1'b0, 11'd183);
		iout_case(11'd80, 11'd0, 1'b1, 11'd0);
		@(posedge sys_clk);
		cal.ioutGain <= 16'h2000;
		cal.ioutOfs <= 11'h000;
		iout_case(11'd13, 11'd0, 1'b0, 11'd0);
		iout_case(11'd14, 11'd0, 1'b0, 11'd14);
		iout_case(11'd80, 11'h7f0, 1'b0, 11'd79);
		rd(CMD_TEMP_READ, {5'h1e, 11'h7f0});
		// Each sticky flag from a one-cycle event, then cleared.
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			evt <= tsr_evt_t'(evtTab[i]);
			@(posedge sys_clk);
			evt <= '0;
			rd(codeTab[i], {8'h00, byteTab[i]});
			rd(CMD_FAULT_WORD, wordTab[i]);
			wr(CMD_CLEAR_FAULTS, 16'h0, 1'b1, 1'b0);
			rd(codeTab[i], 16'h0000);
		end
		// Live summary bits follow their conditions.
		@(posedge sys_clk);
		evt <= tsr_evt_t'(10'h003);
		rd(CMD_FAULT_WORD, 16'h0840);
		@(posedge sys_clk);
		evt <= '0;
		rd(CMD_FAULT_WORD, 16'h0000);
		// Communication errors.
		xact(1'b0, 8'h55, 16'h0, 1'b1, 1'b1, 16'h0);
		rd(CMD_COMM_FLAGS, 16'h0080);
		rd(CMD_FAULT_WORD, 16'h0002);
		wr(CMD_CLEAR_FAULTS, 16'h0, 1'b1, 1'b0);
		wr(CMD_VOUT_READ, 16'h1234, 1'b1, 1'b1);
		rd(CMD_COMM_FLAGS, 16'h0040);
		wr(CMD_CLEAR_FAULTS, 16'h0, 1'b1, 1'b0);
		wr(CMD_COEF_FIRST, 16'h0bad, 1'b0, 1'b1);
		rd(CMD_COMM_FLAGS, 16'h0020);
		rd(CMD_COEF_FIRST, 16'ha5a0);
		wr(CMD_CLEAR_FAULTS, 16'h0, 1'b0, 1'b1);
		rd(CMD_COMM_FLAGS, 16'h0020);
		wr(CMD_CLEAR_FAULTS, 16'h0, 1'b1, 1'b0);
		rd(CMD_COMM_FLAGS, 16'h0000);
		// A new event in the clear cycle survives the clear.
		fork
			wr(CMD_CLEAR_FAULTS, 16'h0, 1'b1, 1'b0);
			begin
				@(posedge sys_clk);
				evt <= tsr_evt_t'(10'h200);
				@(posedge sys_clk);
				evt <= '0;
			end
		join
		rd(CMD_VOUT_FLAGS, 16'h0080);
		// A reset in mid-run restores coefficients and clears flags.
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CMD_COEF_FIRST, PROP_RESET);
		chk(loopCoef.filter, FILT_RESET, "coef after reset");
		rd(CMD_VOUT_FLAGS, 16'h0000);
		print_verdict();
	end

endmodule // tb_top
